// ===== frm_defs.svh
// constants shared by both ends of the serial memory link
`ifndef FRM_DEFS_SVH
`define FRM_DEFS_SVH

// command opcodes understood by the memory end
`define FRM_OP_WREN 8'h06
`define FRM_OP_WRDI 8'h04
`define FRM_OP_RDSR 8'h05
`define FRM_OP_WRSR 8'h01
`define FRM_OP_READ 8'h03
`define FRM_OP_FSTRD 8'h0B
`define FRM_OP_WRITE 8'h02

// status byte layout
`define FRM_ST_PROTECT_PIN_ENABLE_BIT 7
`define FRM_ST_FIXED1 6
`define FRM_ST_BP1 3
`define FRM_ST_BP0 2
`define FRM_ST_WRITE_LATCH_FLAG 1
`define FRM_ST_RESET 8'h40

// array geometry: 131072 bytes, 17-bit byte address
`define FRM_ADDR_W 17
`define FRM_MEM_BYTES 131072
`define FRM_ADDR_BYTES 2'h3

// link timing
`define FRM_SYS_HZ 10000000
`define FRM_SCK_MAX_HZ 40000000
// least half period in system cycles from the rate limit, never below one
`define FRM_SCK_HALF_MIN ((`FRM_SYS_HZ + 2 * `FRM_SCK_MAX_HZ - 1) / (2 * `FRM_SCK_MAX_HZ))
// used half period: the returned bit must clear a two-flop synchroniser
`define FRM_SCK_HALF 4

`endif

// ===== frm_pkg.sv
// types shared by both ends of the serial memory link
package frm_pkg;

    // memory end command sequencer, gray only along opcode-address-dummy-read data
    typedef enum logic [2:0] {
        FRM_S_OPC = 3'h0,
        FRM_S_ADDR = 3'h1,
        FRM_S_DUMMY = 3'h3,
        FRM_S_RDATA = 3'h2,
        FRM_S_WDATA = 3'h6,
        FRM_S_STRD = 3'h7,
        FRM_S_STWR = 3'h5,
        FRM_S_IGNORE = 3'h4
    } frm_dev_state_t;

    // master end sequencer
    typedef enum logic [1:0] {
        FRM_M_IDLE = 2'h0,
        FRM_M_SETUP = 2'h1,
        FRM_M_RUN = 2'h3,
        FRM_M_DONE = 2'h2
    } frm_mst_state_t;

endpackage

// ===== frm_spi_if.sv
// link pins between the bus master and the memory end
`timescale 1ns/1ps
`default_nettype none

interface frm_spi_if;
    logic cs_n;    // chip select, active low, master driven
    logic sck;     // serial clock, master driven
    logic si;      // data into the memory end
    logic so;      // data out of the memory end
    logic so_oe;   // high while the memory end drives so
    logic hold_n;  // pause, active low, master driven
    logic wp_n;    // write protect, active low, master driven
    logic so_line; // resolved output line, weak pull-up when undriven

    // undriven output reads high, as with an external pull-up
    assign so_line = so_oe ? so : 1'b1;

    modport dev (
        input cs_n,
        input sck,
        input si,
        input hold_n,
        input wp_n,
        output so,
        output so_oe
    );

    modport mst (
        output cs_n,
        output sck,
        output si,
        output hold_n,
        output wp_n,
        input so_line
    );
endinterface

`default_nettype wire

// ===== frm_master.sv
// bus master end: builds sck from sys_clk and runs one command per request
`timescale 1ns/1ps
`default_nettype none
`include "frm_defs.svh"

module frm_master #(
    parameter int HALF = `FRM_SCK_HALF // R4
) (
    frm_spi_if.mst link,
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] req_opcode,
    input wire logic [`FRM_ADDR_W-1:0] req_addr,
    input wire logic req_use_addr,
    input wire logic req_use_dummy,
    input wire logic req_use_data,
    input wire logic [7:0] req_wdata,
    input wire logic pause_req,
    input wire logic write_protect_n,
    output logic done,
    output logic [7:0] rdata
);
    frm_pkg::frm_mst_state_t state_q, state_d; // sequencer
    logic [7:0] div_q, div_d;      // half period counter
    logic [39:0] tx_q, tx_d;       // outgoing bits, msb first
    logic [5:0] cnt_q, cnt_d;      // bits still to send
    logic [7:0] rx_q, rx_d;        // last byte returned
    logic cs_n_q, cs_n_d;
    logic sck_q, sck_d;
    logic si_q, si_d;
    logic hold_n_q, hold_n_d;
    logic wp_n_q;
    logic ready_q, ready_d;
    logic done_q, done_d;
    logic [7:0] rdata_q, rdata_d;
    logic [1:0] so_sync_q;         // returned line, two flops deep, apart from si R16
    logic tick;
    logic [2:0] nbytes;

    // next state of the link sequencer
    always_comb
    begin
        tick = (div_q == 8'(HALF - 1));
        nbytes = 3'h1 + (req_use_addr ? 3'h3 : 3'h0) + (req_use_dummy ? 3'h1 : 3'h0)
            + (req_use_data ? 3'h1 : 3'h0);
        state_d = state_q;
        div_d = tick ? 8'h00 : div_q + 8'h01;
        tx_d = tx_q;
        cnt_d = cnt_q;
        rx_d = rx_q;
        cs_n_d = cs_n_q;
        sck_d = sck_q;
        si_d = si_q;
        hold_n_d = hold_n_q;
        ready_d = ready_q;
        done_d = 1'b0;
        rdata_d = rdata_q;
        case (state_q)
            frm_pkg::FRM_M_IDLE:
            begin
                hold_n_d = 1'b1;
                ready_d = 1'b1;
                div_d = 8'h00;
                if (req_valid && ready_q)
                begin
                    // a fresh select edge opens every command; msb first R2 R13 R17
                    tx_d = {req_opcode, 7'h00, req_addr, req_wdata};
                    if (!req_use_addr)
                    begin
                        tx_d = {req_opcode, req_wdata, 24'h000000};
                    end
                    cnt_d = {nbytes, 3'h0};
                    si_d = req_opcode[7];
                    cs_n_d = 1'b0; // R15
                    ready_d = 1'b0;
                    state_d = frm_pkg::FRM_M_SETUP;
                end
            end
            frm_pkg::FRM_M_SETUP:
            begin
                if (tick)
                begin
                    state_d = frm_pkg::FRM_M_RUN;
                end
            end
            frm_pkg::FRM_M_RUN:
            begin
                if (tick && !sck_q)
                begin
                    // pause pin moves only with sck low R8
                    hold_n_d = !pause_req;
                    if (!pause_req && hold_n_q)
                    begin
                        sck_d = 1'b1;
                    end
                end
                else if (tick)
                begin
                    // falling edge: take returned bit, present next bit
                    sck_d = 1'b0;
                    rx_d = {rx_q[6:0], so_sync_q[1]};
                    tx_d = {tx_q[38:0], 1'b0};
                    si_d = tx_q[38];
                    cnt_d = cnt_q - 6'h01;
                    if (cnt_q == 6'h01)
                    begin
                        state_d = frm_pkg::FRM_M_DONE;
                    end
                end
            end
            frm_pkg::FRM_M_DONE:
            begin
                if (tick)
                begin
                    // release select before any further opcode R14
                    cs_n_d = 1'b1;
                    done_d = 1'b1;
                    rdata_d = rx_q;
                    state_d = frm_pkg::FRM_M_IDLE;
                end
            end
            default:
            begin
                state_d = frm_pkg::FRM_M_IDLE;
            end
        endcase
    end

    // register the sequencer and the pins
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_q <= frm_pkg::FRM_M_IDLE;
            div_q <= 8'h00;
            tx_q <= 40'h0000000000;
            cnt_q <= 6'h00;
            rx_q <= 8'h00;
            cs_n_q <= 1'b1;
            sck_q <= 1'b0;
            si_q <= 1'b0;
            hold_n_q <= 1'b1;
            wp_n_q <= 1'b1;
            ready_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= 8'h00;
            so_sync_q <= 2'h3;
        end
        else
        begin
            state_q <= state_d;
            div_q <= div_d;
            tx_q <= tx_d;
            cnt_q <= cnt_d;
            rx_q <= rx_d;
            cs_n_q <= cs_n_d;
            sck_q <= sck_d;
            si_q <= si_d;
            hold_n_q <= hold_n_d;
            wp_n_q <= write_protect_n;
            ready_q <= ready_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
            so_sync_q <= {so_sync_q[0], link.so_line};
        end
    end

    assign link.cs_n = cs_n_q;
    assign link.sck = sck_q; // mode 0: idles low R12
    assign link.si = si_q;
    assign link.hold_n = hold_n_q;
    assign link.wp_n = wp_n_q;
    assign req_ready = ready_q;
    assign done = done_q;
    assign rdata = rdata_q;
endmodule

`default_nettype wire

// ===== frm_device.sv
// memory end: serial command front end with its byte array
// Summary of operation
// R1 - select high: idle, ignore inputs, output off
// R2 - master opens each opcode with select falling
// R3 - sample on sck rise, change output on fall
// R4 - any sck rate to limit, fully static
// R5 - drive output only for returned read data
// R6 - protect bit plus low pin blocks status write
// R7 - pause low freezes the command in progress
// R8 - master moves pause only while sck low
// R9 - array of 131072 bytes, 17-bit address
// R10 - three address bytes, top seven bits ignored
// R11 - writes finish at bus speed, never busy
// R12 - modes 0 and 3, first rise samples
// R13 - opcode first, then address, then data
// R14 - master releases select between commands
// R15 - memory end is a pure slave
// R16 - joined data line: master stays off during reads; here si and so stay separate and the master drives si throughout
// R17 - every byte shifted most significant bit first
// R18 - unknown opcode: ignore until next select
// R19 - sck level at select selects the mode
// R20 - select rise after WRDI/WRSR/WRITE drops latch
// R21 - pause release resumes at the same bit
`timescale 1ns/1ps
`default_nettype none
`include "frm_defs.svh"

module frm_device #(
    parameter int ADDR_W = `FRM_ADDR_W,
    parameter int MEM_BYTES = `FRM_MEM_BYTES
) (
    frm_spi_if.dev link,
    input wire logic sys_clk,
    input wire logic rst,
    output logic write_latch_flag,
    output logic protect_pin_enable_bit,
    output logic selected
);
    // array storage, no reset: contents survive like nonvolatile cells
    logic [7:0] mem [0:MEM_BYTES-1]; // R9

    frm_pkg::frm_dev_state_t state_q, state_d; // per frame sequencer
    logic [2:0] bit_q, bit_d;       // bit within byte
    logic [1:0] byte_q, byte_d;     // address byte count
    logic [6:0] shift_q, shift_d;   // bits received so far
    logic [7:0] cmd_q, cmd_d;       // opcode of this frame
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [7:0] tx_q, tx_d;         // byte being returned
    logic prot_en_q, prot_en_d;     // protect_pin_enable_bit, arms the pin veto
    logic [1:0] bp_q, bp_d;         // block protect bits, stored only
    logic set_tgl_q, set_tgl_d;     // flips on each latch set
    logic clr_tgl_q, clr_tgl_d;     // flips on each latch clear
    logic pend_clr_q, pend_clr_d;   // this command drops the latch at select rise
    logic so_q, so_d;
    logic oe_q, oe_d;
    logic mode3_q;                  // 1 when selected with sck high
    logic por_q;                    // registered system reset
    logic latch_on;                 // write latch as the array sees it
    logic [7:0] rx_byte;
    logic [7:0] status;
    logic mem_we;
    logic [ADDR_W-1:0] addr_next;
    logic [2:0] sync1_q, sync2_q, flag_q;

    // opcode to first state after it; unknowns go quiet R18
    function automatic frm_pkg::frm_dev_state_t op_state(input logic [7:0] op);
        case (op)
            `FRM_OP_READ, `FRM_OP_FSTRD, `FRM_OP_WRITE: op_state = frm_pkg::FRM_S_ADDR;
            `FRM_OP_RDSR: op_state = frm_pkg::FRM_S_STRD;
            `FRM_OP_WRSR: op_state = frm_pkg::FRM_S_STWR;
            default: op_state = frm_pkg::FRM_S_IGNORE;
        endcase
    endfunction

    // commands whose select rise clears the write latch
    function automatic logic op_clears(input logic [7:0] op);
        op_clears = (op == `FRM_OP_WRDI) || (op == `FRM_OP_WRSR) || (op == `FRM_OP_WRITE);
    endfunction

    assign latch_on = set_tgl_q ^ clr_tgl_q;
    assign status = {prot_en_q, 3'h4, bp_q, latch_on, 1'b0} | `FRM_ST_RESET;
    assign rx_byte = {shift_q, link.si};
    assign addr_next = addr_q + ADDR_W'(1);

    // power-on: system reset registered, then used as a constant clear
    always_ff @(posedge sys_clk)
    begin
        por_q <= rst;
    end

    // mode seen at the select edge; rise sampling serves both modes R19 R12
    always_ff @(negedge link.cs_n)
    begin
        mode3_q <= link.sck;
    end

    // next values of the receive side, computed for each rising sck
    always_comb
    begin
        state_d = state_q;
        bit_d = bit_q;
        byte_d = byte_q;
        shift_d = shift_q;
        cmd_d = cmd_q;
        addr_d = addr_q;
        tx_d = tx_q;
        prot_en_d = prot_en_q;
        bp_d = bp_q;
        set_tgl_d = set_tgl_q;
        pend_clr_d = pend_clr_q;
        mem_we = 1'b0;
        // pause low: everything holds where it is R7 R21
        if (link.hold_n)
        begin
            shift_d = rx_byte[6:0]; // msb arrives first R17 R3
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7)
            begin
                case (state_q)
                    frm_pkg::FRM_S_OPC:
                    begin
                        // first whole byte is the opcode R13
                        cmd_d = rx_byte;
                        state_d = op_state(rx_byte);
                        pend_clr_d = op_clears(rx_byte);
                        tx_d = status;
                        if (rx_byte == `FRM_OP_WREN)
                        begin
                            set_tgl_d = set_tgl_q ^ !latch_on;
                        end
                    end
                    frm_pkg::FRM_S_ADDR:
                    begin
                        // top seven bits fall off the narrow register R10
                        addr_d = ADDR_W'({addr_q, rx_byte});
                        byte_d = byte_q + 2'h1;
                        if (byte_q == `FRM_ADDR_BYTES - 2'h1)
                        begin
                            tx_d = mem[ADDR_W'({addr_q, rx_byte})];
                            if (cmd_q == `FRM_OP_WRITE)
                            begin
                                state_d = frm_pkg::FRM_S_WDATA;
                            end
                            else if (cmd_q == `FRM_OP_FSTRD)
                            begin
                                state_d = frm_pkg::FRM_S_DUMMY;
                            end
                            else
                            begin
                                state_d = frm_pkg::FRM_S_RDATA;
                            end
                        end
                    end
                    frm_pkg::FRM_S_DUMMY:
                    begin
                        state_d = frm_pkg::FRM_S_RDATA;
                    end
                    frm_pkg::FRM_S_RDATA:
                    begin
                        // sequential read, wraps at the top of the array
                        addr_d = addr_next;
                        tx_d = mem[addr_next];
                    end
                    frm_pkg::FRM_S_WDATA:
                    begin
                        // byte lands at once, no busy phase R11
                        mem_we = latch_on;
                        addr_d = addr_next;
                    end
                    frm_pkg::FRM_S_STRD:
                    begin
                        tx_d = status;
                    end
                    frm_pkg::FRM_S_STWR:
                    begin
                        // latch needed, and pin protection may veto R6
                        if (latch_on && !(prot_en_q && !link.wp_n))
                        begin
                            prot_en_d = rx_byte[`FRM_ST_PROTECT_PIN_ENABLE_BIT];
                            bp_d = {rx_byte[`FRM_ST_BP1], rx_byte[`FRM_ST_BP0]};
                        end
                        state_d = frm_pkg::FRM_S_IGNORE;
                    end
                    default:
                    begin
                        state_d = frm_pkg::FRM_S_IGNORE; // R18
                    end
                endcase
            end
        end
    end

    // frame state: select high clears it to a constant, so each frame
    // starts clean even if sck stopped mid-byte R1 R4 R15
    always_ff @(posedge link.sck or posedge link.cs_n)
    begin
        if (link.cs_n)
        begin
            state_q <= frm_pkg::FRM_S_OPC;
            bit_q <= 3'h0;
            byte_q <= 2'h0;
            shift_q <= 7'h00;
        end
        else
        begin
            state_q <= state_d;
            bit_q <= bit_d;
            byte_q <= byte_d;
            shift_q <= shift_d;
        end
    end

    // frame data that needs no clearing between frames
    always_ff @(posedge link.sck)
    begin
        cmd_q <= cmd_d;
        addr_q <= addr_d;
        tx_q <= tx_d;
    end

    // array write port R11
    always_ff @(posedge link.sck)
    begin
        if (mem_we && !link.cs_n)
        begin
            mem[addr_q] <= rx_byte;
        end
    end

    // persistent status, cleared only at power-on
    always_ff @(posedge link.sck or posedge por_q)
    begin
        if (por_q)
        begin
            prot_en_q <= 1'(`FRM_ST_RESET >> `FRM_ST_PROTECT_PIN_ENABLE_BIT);
            bp_q <= 2'h0;
            set_tgl_q <= 1'b0;
            pend_clr_q <= 1'b0;
        end
        else if (!link.cs_n)
        begin
            prot_en_q <= prot_en_d;
            bp_q <= bp_d;
            set_tgl_q <= set_tgl_d;
            pend_clr_q <= pend_clr_d;
        end
    end

    // latch drop at the select rise that ends the command R20
    always_comb
    begin
        clr_tgl_d = clr_tgl_q ^ (pend_clr_q & latch_on);
    end

    always_ff @(posedge link.cs_n or posedge por_q)
    begin
        if (por_q)
        begin
            clr_tgl_q <= 1'b0;
        end
        else
        begin
            clr_tgl_q <= clr_tgl_d;
        end
    end

    // output side: moves on falling sck only, msb first R3 R17
    always_comb
    begin
        so_d = so_q;
        oe_d = oe_q;
        if (link.hold_n)
        begin
            oe_d = (state_q == frm_pkg::FRM_S_RDATA) || (state_q == frm_pkg::FRM_S_STRD);
            so_d = tx_q[3'h7 - bit_q];
        end
    end

    // select high forces the driver off at once R1
    always_ff @(negedge link.sck or posedge link.cs_n)
    begin
        if (link.cs_n)
        begin
            so_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else
        begin
            so_q <= so_d;
            oe_q <= oe_d;
        end
    end

    // the pause pin cuts the driver without waiting for an edge R5
    assign link.so = so_q;
    assign link.so_oe = oe_q & link.hold_n;

    // status levels into the system domain, three flops each
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    flag_q[gi] <= 1'b0;
                end
                else
                begin
                    sync1_q[gi] <= gi == 0 ? latch_on : (gi == 1 ? prot_en_q : !link.cs_n);
                    sync2_q[gi] <= sync1_q[gi];
                    flag_q[gi] <= sync2_q[gi];
                end
            end
        end
    endgenerate

    assign write_latch_flag = flag_q[0];
    assign protect_pin_enable_bit = flag_q[1];
    assign selected = flag_q[2];
endmodule

`default_nettype wire

// ===== frm_link_monitor.sv
// concurrent checks on the serial memory link pins
`timescale 1ns/1ps
`default_nettype none

module frm_link_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic so_line
);
    logic [6:0] rise_cnt_q; // sck rises seen in this frame
    logic [6:0] rise_cnt_d;
    logic sck_q; // sck one cycle back, for edge finding

    // count rises; cleared while deselected so each frame starts at zero
    always_comb
    begin
        rise_cnt_d = rise_cnt_q;
        if (cs_n)
        begin
            rise_cnt_d = 7'h00;
        end
        else if (sck && !sck_q)
        begin
            rise_cnt_d = rise_cnt_q + 7'h01;
        end
    end

    // register the counter and the delayed clock level
    always_ff @(posedge sys_clk)
    begin
        rise_cnt_q <= rst ? 7'h00 : rise_cnt_d;
        sck_q <= rst ? 1'b0 : sck;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_idle_output_off: assert property (cs_n |-> !so_oe)
        else $error("output driven while deselected");
    a_pause_output_off: assert property (!hold_n |-> !so_oe)
        else $error("output driven while paused");
    a_so_on_fall: assert property ((so != $past(so)) && so_oe && $past(so_oe) |-> $fell(sck))
        else $error("output moved away from a falling clock");
    // output starts only after opcode, opcode plus address, or plus dummy
    a_oe_on_fall: assert property ($rose(so_oe) && $past(hold_n) |-> $fell(sck) &&
        (rise_cnt_q == 7'h08 || rise_cnt_q == 7'h20 || rise_cnt_q == 7'h28))
        else $error("output enabled at a wrong bit");
    a_oe_after_op: assert property (so_oe |-> rise_cnt_q >= 7'h08)
        else $error("output during the opcode byte");
    a_si_on_fall: assert property (!cs_n && !$past(cs_n) && (si != $past(si)) |-> $fell(sck))
        else $error("input data moved away from a falling clock");
    a_hold_sck_low: assert property ((hold_n != $past(hold_n)) |-> !sck && !$past(sck))
        else $error("pause moved while clock high");
    a_idle_sck_low: assert property (cs_n |-> !sck)
        else $error("clock high outside a frame");
    a_whole_bytes: assert property ($rose(cs_n) |-> rise_cnt_q[2:0] == 3'h0)
        else $error("frame ended mid byte");
endmodule

`default_nettype wire

// ===== serial_fram_spi_slave_front_end_test.sv
// self-checking bench joining the master end to the memory end
`timescale 1ns/1ps
`default_nettype none
`include "frm_defs.svh"

module serial_fram_spi_slave_front_end_test;
    logic sys_clk = 1'b0; // 10 MHz system clock
    logic rst = 1'b1; // synchronous reset, held at start
    logic req_valid = 1'b0;
    logic req_ready;
    logic [7:0] req_opcode = 8'h00;
    logic [16:0] req_addr = 17'h00000;
    logic req_use_addr = 1'b0;
    logic req_use_dummy = 1'b0;
    logic req_use_data = 1'b0;
    logic [7:0] req_wdata = 8'h00;
    logic pause_req = 1'b0; // asks the master to pause the link
    logic write_protect_n = 1'b1;
    logic done;
    logic [7:0] rdata;
    logic write_latch_flag;
    logic protect_pin_enable_bit;
    logic selected;
    logic [7:0] rd; // byte returned by the last command
    logic [16:0] adrs [4] = '{17'h00000, 17'h10000, 17'h1FFFF, 17'h0ABCD};
    logic [7:0] dats [4] = '{8'h11, 8'h22, 8'hA5, 8'h3C};
    int failures = 0;
    int n_checks = 0;

    frm_spi_if frm_spi_if_i ();

    frm_master frm_master_i (.link(frm_spi_if_i), .sys_clk(sys_clk), .rst(rst),
        .req_valid(req_valid), .req_ready(req_ready), .req_opcode(req_opcode),
        .req_addr(req_addr), .req_use_addr(req_use_addr), .req_use_dummy(req_use_dummy),
        .req_use_data(req_use_data), .req_wdata(req_wdata), .pause_req(pause_req),
        .write_protect_n(write_protect_n), .done(done), .rdata(rdata));

    frm_device frm_device_i (.link(frm_spi_if_i), .sys_clk(sys_clk), .rst(rst),
        .write_latch_flag(write_latch_flag),
        .protect_pin_enable_bit(protect_pin_enable_bit), .selected(selected));

    frm_link_monitor frm_link_monitor_i (.sys_clk(sys_clk), .rst(rst),
        .cs_n(frm_spi_if_i.cs_n), .sck(frm_spi_if_i.sck), .si(frm_spi_if_i.si),
        .so(frm_spi_if_i.so), .so_oe(frm_spi_if_i.so_oe), .hold_n(frm_spi_if_i.hold_n),
        .wp_n(frm_spi_if_i.wp_n), .so_line(frm_spi_if_i.so_line));

    // half period of 50 ns
    always #50 sys_clk = ~sys_clk;

    // compare one value and count it
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one command; fl is {address, dummy, data}; waits are bounded
    task automatic cmd(input logic [7:0] op, input logic [16:0] adr, input logic [2:0] fl,
        input logic [7:0] wd);
        int n;
        @(posedge sys_clk);
        #1;
        req_opcode = op;
        req_addr = adr;
        {req_use_addr, req_use_dummy, req_use_data} = fl;
        req_wdata = wd;
        req_valid = 1'b1;
        n = 0;
        while (req_ready !== 1'b1 && n < 100)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 2000)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 2000)
            failures++;
        rd = rdata;
    endtask

    // shorthand commands
    task automatic wren();
        cmd(`FRM_OP_WREN, 17'h00000, 3'h0, 8'h00);
    endtask
    task automatic rd_status();
        cmd(`FRM_OP_RDSR, 17'h00000, 3'h1, 8'h00);
    endtask
    // flags pass a three-flop synchroniser, so let them settle first
    task automatic flags(input logic latch_exp, input logic prot_exp);
        repeat (5) @(posedge sys_clk);
        #1;
        check({7'h00, write_latch_flag}, {7'h00, latch_exp});
        check({7'h00, protect_pin_enable_bit}, {7'h00, prot_exp});
        check({7'h00, selected}, 8'h00);
    endtask

    // print counts and verdict, then stop
    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (2) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        rd_status();
        check(rd, 8'h40);
        flags(1'b0, 1'b0);
        wren();
        rd_status();
        check(rd, 8'h42);
        flags(1'b1, 1'b0);
        cmd(`FRM_OP_WRDI, 17'h00000, 3'h0, 8'h00);
        rd_status();
        check(rd, 8'h40);
        $display("test latch done");
        for (int i = 0; i < 4; i++)
        begin
            wren();
            cmd(`FRM_OP_WRITE, adrs[i], 3'h5, dats[i]);
        end
        flags(1'b0, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            cmd(`FRM_OP_READ, adrs[i], 3'h5, 8'h00);
            check(rd, dats[i]);
        end
        cmd(`FRM_OP_WRITE, adrs[0], 3'h5, 8'hFF);
        cmd(`FRM_OP_READ, adrs[0], 3'h5, 8'h00);
        check(rd, dats[0]);
        cmd(`FRM_OP_FSTRD, adrs[1], 3'h7, 8'h00);
        check(rd, dats[1]);
        $display("test array done");
        wren();
        cmd(`FRM_OP_WRSR, 17'h00000, 3'h1, 8'h8C);
        rd_status();
        check(rd, 8'hCC);
        flags(1'b0, 1'b1);
        write_protect_n = 1'b0;
        wren();
        cmd(`FRM_OP_WRSR, 17'h00000, 3'h1, 8'h00);
        rd_status();
        check(rd, 8'hCC);
        write_protect_n = 1'b1;
        wren();
        cmd(`FRM_OP_WRSR, 17'h00000, 3'h1, 8'h00);
        rd_status();
        check(rd, 8'h40);
        $display("test protect done");
        cmd(8'h9F, 17'h00000, 3'h1, 8'h00);
        check(rd, 8'hFF);
        rd_status();
        check(rd, 8'h40);
        $display("test unknown done");
        fork
            cmd(`FRM_OP_READ, adrs[3], 3'h5, 8'h00);
            begin
                // lands inside the returned data byte, so the driver must drop
                repeat (290) @(posedge sys_clk);
                #1;
                pause_req = 1'b1;
                repeat (40) @(posedge sys_clk);
                #1;
                check({7'h00, selected}, 8'h01);
                pause_req = 1'b0;
            end
        join
        check(rd, dats[3]);
        $display("test pause done");
        final_report();
    end

    // watchdog well beyond the expected run length
    initial
    begin
        #5000000;
        failures++;
        final_report();
    end
endmodule

`default_nettype wire
